// ---- rtl/dmic_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dmic_regs.svh"
module dmic_ctrl #(
  parameter int N_SRC       = 8,
  parameter int N_EXT       = 2,
  parameter int SRC_PER_MOD = 2
) (
  input  wire logic                   clk,
  input  wire logic                   srst,
  input  wire logic                   ce,
  input  wire logic [7:0]             avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  output logic [31:0]                 avs_readdata,
  output logic                        avs_waitrequest,
  input  wire logic                   nmi_pin,
  input  wire logic [N_EXT-1:0]       ext_pin,
  input  wire logic [N_SRC-N_EXT-1:0] int_flag,
  dmic_if.ctl                         irq
);
  import dmic_pkg::*;
  localparam int NM = N_SRC / SRC_PER_MOD;
  localparam int IW = $clog2(N_SRC);
  localparam int NS = N_EXT + 1;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [NS-1:0] s1_q, s2_q, s3_q, st_q, st_d;
  logic          nmi_prev_q, nmi_old_q;

  always_comb
  begin
    st_d = ((s2_q ^ s3_q) & st_q) | (~(s2_q ^ s3_q) & s3_q);
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s1_q       <= '0;
      s2_q       <= '0;
      s3_q       <= '0;
      st_q       <= '0;
      nmi_prev_q <= 1'b0;
      nmi_old_q  <= 1'b0;
    end
    else if (ce)
    begin
      s1_q       <= {nmi_pin, ext_pin};
      s2_q       <= s1_q;
      s3_q       <= s2_q;
      st_q       <= st_d;
      nmi_prev_q <= st_q[N_EXT];
      nmi_old_q  <= nmi_prev_q;
    end
  end

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  logic [1:0]      mode_q, mode_d;
  logic [N_SRC-1:0] en_q, en_d;
  logic [3*NM-1:0] lvlr_q, lvlr_d;
  dmic_vec_t       lastv_q, lastv_d;
  logic            ack_q, ack_d;
  logic [31:0]     rd_q, rd_d, rdec;
  logic            wr_go;
  logic            mode2;
  logic [N_SRC-1:0] req_q, req_d;
  logic            nmi_pend_q, nmi_pend_d;
  logic [N_EXT-1:0] ext_q, ext_d;
  logic            win_valid_q, win_nmi_q;
  dmic_vec_t       win_vec_q, win_vec_d;
  dmic_lvl_t       win_lvl_q;
  logic            sel_valid, sel_nmi;
  logic [IW-1:0]   sel_idx;
  dmic_lvl_t       sel_lvl;
  dmic_lvl_t       lvl_src [N_SRC];

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign avs_readdata    = rd_q;
  assign wr_go           = avs_write & ack_q;
  assign mode2           = mode_q == `DMIC_MODE2;
  assign irq.mode        = mode_q;

  always_comb
  begin
    if (avs_address == `DMIC_OFF_SYSCTL)
      rdec = 32'(mode_q);
    else if (avs_address == `DMIC_OFF_ENABLE)
      rdec = 32'(en_q);
    else if (avs_address == `DMIC_OFF_LEVEL)
      rdec = 32'(lvlr_q);
    else if (avs_address == `DMIC_OFF_PEND)
      rdec = 32'({nmi_pend_q, req_q});
    else if (avs_address == `DMIC_OFF_LASTV)
      rdec = 32'(lastv_q);
    else
      rdec = 32'h0000_0000;
  end

  always_comb
  begin
    ack_d   = (avs_read | avs_write) & ~ack_q;
    rd_d    = (avs_read & ~ack_q) ? rdec : rd_q;
    mode_d  = mode_q;
    en_d    = en_q;
    lvlr_d  = lvlr_q;
    lastv_d = irq.irq_ack ? win_vec_q : lastv_q;
    if (wr_go && avs_address == `DMIC_OFF_SYSCTL)
      mode_d = avs_writedata[1:0];
    else if (wr_go && avs_address == `DMIC_OFF_ENABLE)
      en_d = avs_writedata[N_SRC-1:0];
    else if (wr_go && avs_address == `DMIC_OFF_LEVEL)
      lvlr_d = avs_writedata[3*NM-1:0];
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ack_q   <= 1'b0;
      rd_q    <= 32'h0000_0000;
      mode_q  <= `DMIC_MODE0;
      en_q    <= '0;
      lvlr_q  <= '0;
      lastv_q <= 8'h00;
    end
    else if (ce)
    begin
      ack_q   <= ack_d;
      rd_q    <= rd_d;
      mode_q  <= mode_d;
      en_q    <= en_d;
      lvlr_q  <= lvlr_d;
      lastv_q <= lastv_d;
    end
  end

  // ----------------------------------------
  // request collection
  // ----------------------------------------
  always_comb
  begin
    ext_d      = st_q[N_EXT-1:0];
    req_d      = {int_flag, ext_q} & en_q;
    nmi_pend_d = (nmi_prev_q & ~nmi_old_q)
               | (nmi_pend_q & ~(irq.irq_ack & win_nmi_q));
    for (int i = 0; i < N_SRC; i++)
    begin
      lvl_src[i] = lvlr_q[3*(i/SRC_PER_MOD) +: 3];
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ext_q      <= '0;
      req_q      <= '0;
      nmi_pend_q <= 1'b0;
    end
    else if (ce)
    begin
      ext_q      <= ext_d;
      req_q      <= req_d;
      nmi_pend_q <= nmi_pend_d;
    end
  end

  // ----------------------------------------
  // arbitration
  // ----------------------------------------
  dmic_sel #(
    .N_SRC (N_SRC),
    .IW    (IW)
  ) u_sel (
    .nmi    (nmi_pend_q),
    .req    (req_q),
    .lvl    (lvl_src),
    .mode2  (mode2),
    .valid  (sel_valid),
    .idx    (sel_idx),
    .level  (sel_lvl),
    .is_nmi (sel_nmi)
  );

  always_comb
  begin
    win_vec_d = sel_nmi ? `DMIC_NMI_VEC : `DMIC_VEC_BASE + 8'(sel_idx);
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      win_valid_q <= 1'b0;
      win_nmi_q   <= 1'b0;
      win_vec_q   <= 8'h00;
      win_lvl_q   <= 3'h0;
    end
    else if (ce)
    begin
      win_valid_q <= sel_valid;
      win_nmi_q   <= sel_nmi;
      win_vec_q   <= win_vec_d;
      win_lvl_q   <= sel_lvl;
    end
  end

  // ----------------------------------------
  // acceptance against the core masks
  // ----------------------------------------
  always_comb
  begin
    if (win_nmi_q)
      irq.irq_valid = win_valid_q;
    else if (mode2)
      irq.irq_valid = win_valid_q & (win_lvl_q > irq.exr_mask);
    else
      irq.irq_valid = win_valid_q & ~irq.ccr_i;
  end
  assign irq.irq_vec   = win_vec_q;
  assign irq.irq_level = win_lvl_q;
  assign irq.irq_nmi   = win_nmi_q;
endmodule
`default_nettype wire

// ---- rtl/dmic_regs.svh ----
`ifndef DMIC_REGS_SVH
`define DMIC_REGS_SVH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define DMIC_OFF_SYSCTL 8'h00
`define DMIC_OFF_ENABLE 8'h04
`define DMIC_OFF_LEVEL  8'h08
`define DMIC_OFF_PEND   8'h0C
`define DMIC_OFF_LASTV  8'h10
// ----------------------------------------
// fields and values
// ----------------------------------------
`define DMIC_MODE0      2'h0
`define DMIC_MODE2      2'h2
`define DMIC_NMI_VEC    8'h07
`define DMIC_VEC_BASE   8'h10
`define DMIC_LVL_MAX    3'h7
`define DMIC_CCR_I      7
`define DMIC_EXR_T      7
`define DMIC_CCR_RST    8'h80
`define DMIC_EXR_RST    8'h07
// ----------------------------------------
// entry sequence counts
// ----------------------------------------
`define DMIC_STK_M0     2'h2
`define DMIC_STK_M2     2'h3
`define DMIC_VEC_RD     2'h2
`endif

// ---- rtl/dmic_pkg.sv ----
package dmic_pkg;
  typedef logic [2:0] dmic_lvl_t;
  typedef logic [7:0] dmic_vec_t;
  typedef enum logic [2:0] {
    DMIC_S_IDLE = 3'h0,
    DMIC_S_WAIT = 3'h1,
    DMIC_S_PREF = 3'h3,
    DMIC_S_INT1 = 3'h2,
    DMIC_S_STK  = 3'h6,
    DMIC_S_VEC  = 3'h7,
    DMIC_S_INT2 = 3'h5,
    DMIC_S_HFET = 3'h4
  } dmic_cpu_st_t;
endpackage

// ---- rtl/dmic_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface dmic_if;
  import dmic_pkg::*;
  logic      irq_valid;
  dmic_vec_t irq_vec;
  dmic_lvl_t irq_level;
  logic      irq_nmi;
  logic      irq_ack;
  logic [1:0] mode;
  logic      ccr_i;
  dmic_lvl_t exr_mask;
  modport ctl (
    output irq_valid,
    output irq_vec,
    output irq_level,
    output irq_nmi,
    output mode,
    input  irq_ack,
    input  ccr_i,
    input  exr_mask
  );
  modport cpu (
    input  irq_valid,
    input  irq_vec,
    input  irq_level,
    input  irq_nmi,
    input  mode,
    output irq_ack,
    output ccr_i,
    output exr_mask
  );
endinterface
`default_nettype wire

// ---- rtl/dmic_sel.sv ----
`timescale 1ns/1ps
`default_nettype none
module dmic_sel #(
  parameter int N_SRC = 8,
  parameter int IW    = 3
) (
  input  wire logic                 nmi,
  input  wire logic [N_SRC-1:0]     req,
  input  wire dmic_pkg::dmic_lvl_t  lvl [N_SRC],
  input  wire logic                 mode2,
  output logic                      valid,
  output logic [IW-1:0]             idx,
  output dmic_pkg::dmic_lvl_t       level,
  output logic                      is_nmi
);
  import dmic_pkg::*;
  logic      found;
  dmic_lvl_t lv;
  // ----------------------------------------
  // winner search, low index first on ties
  // ----------------------------------------
  always_comb
  begin
    found = 1'b0;
    idx   = '0;
    lv    = '0;
    for (int i = N_SRC - 1; i >= 0; i--)
    begin
      if (req[i] && (!found || !mode2 || lvl[i] >= lv))
      begin
        found = 1'b1;
        idx   = i[IW-1:0];
        lv    = mode2 ? lvl[i] : '0;
      end
    end
    is_nmi = nmi;
    valid  = nmi | found;
    level  = nmi ? `DMIC_LVL_MAX : lv;
  end
endmodule
`default_nettype wire

// ---- rtl/dmic_cpu.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dmic_regs.svh"
module dmic_cpu (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        ce,
  dmic_if.cpu              irq,
  input  wire logic        instr_done,
  input  wire logic [23:0] pc_next,
  input  wire logic [15:0] sp,
  input  wire logic        ccr_we,
  input  wire logic [7:0]  ccr_wdata,
  input  wire logic        exr_we,
  input  wire logic [7:0]  exr_wdata,
  input  wire logic [15:0] mem_rdata,
  output logic             mem_req,
  output logic             mem_we,
  output logic [23:0]      mem_addr,
  output logic [15:0]      mem_wdata,
  output logic [7:0]       condition_code_reg,
  output logic [7:0]       extended_status_reg,
  output logic             handler_go,
  output logic [23:0]      handler_pc,
  output logic             busy
);
  import dmic_pkg::*;
  dmic_cpu_st_t st_q, st_d;
  logic [1:0]   cnt_q, cnt_d, stk_n;
  dmic_vec_t    vec_q, vec_d;
  dmic_lvl_t    lvl_q, lvl_d;
  logic         nmi_q, nmi_d, m2_q, m2_d;
  logic [23:0]  pc_q, pc_d;
  logic [15:0]  hi_q, hi_d, lo_q, lo_d;
  logic [7:0]   ccr_q, ccr_d, exr_q, exr_d;
  logic         go_d, req_d, we_d;
  logic [23:0]  addr_d;
  logic [15:0]  wdata_d;

  function automatic logic [23:0] vaddr(dmic_vec_t v, logic [1:0] k);
    vaddr = {14'h0, v, 2'b00} + {21'h0, k, 1'b0};
  endfunction

  // ----------------------------------------
  // entry sequence
  // ----------------------------------------
  assign irq.irq_ack  = ce & (st_q == DMIC_S_IDLE) & irq.irq_valid;
  assign irq.ccr_i    = ccr_q[`DMIC_CCR_I];
  assign irq.exr_mask = exr_q[2:0];
  assign condition_code_reg          = ccr_q;
  assign extended_status_reg          = exr_q;
  assign busy         = st_q != DMIC_S_IDLE;
  assign stk_n        = m2_q ? `DMIC_STK_M2 : `DMIC_STK_M0;

  always_comb
  begin
    st_d  = st_q;
    cnt_d = cnt_q;
    vec_d = vec_q;
    lvl_d = lvl_q;
    nmi_d = nmi_q;
    m2_d  = m2_q;
    pc_d  = pc_q;
    hi_d  = hi_q;
    lo_d  = lo_q;
    go_d  = 1'b0;
    ccr_d = ccr_we ? ccr_wdata : ccr_q;
    exr_d = exr_we ? exr_wdata : exr_q;
    case (st_q)
      DMIC_S_IDLE:
        if (irq.irq_valid)
        begin
          vec_d = irq.irq_vec;
          lvl_d = irq.irq_level;
          nmi_d = irq.irq_nmi;
          m2_d  = irq.mode == `DMIC_MODE2;
          st_d  = DMIC_S_WAIT;
        end
      DMIC_S_WAIT:
        if (instr_done)
        begin
          pc_d = pc_next;
          st_d = DMIC_S_PREF;
        end
      DMIC_S_PREF:
        st_d = DMIC_S_INT1;
      DMIC_S_INT1:
      begin
        st_d  = DMIC_S_STK;
        cnt_d = 2'h0;
      end
      DMIC_S_STK:
        if (cnt_q == stk_n - 2'h1)
        begin
          st_d  = DMIC_S_VEC;
          cnt_d = 2'h0;
          if (m2_q)
          begin
            exr_d[`DMIC_EXR_T] = 1'b0;
            exr_d[2:0]         = nmi_q ? `DMIC_LVL_MAX : lvl_q;
          end
          else
            ccr_d[`DMIC_CCR_I] = 1'b1;
        end
        else
          cnt_d = cnt_q + 2'h1;
      DMIC_S_VEC:
      begin
        if (cnt_q == 2'h0)
          hi_d = mem_rdata;
        else
          lo_d = mem_rdata;
        if (cnt_q == `DMIC_VEC_RD - 2'h1)
          st_d = DMIC_S_INT2;
        else
          cnt_d = cnt_q + 2'h1;
      end
      DMIC_S_INT2:
        st_d = DMIC_S_HFET;
      default:
      begin
        st_d = DMIC_S_IDLE;
        go_d = 1'b1;
      end
    endcase
  end

  // ----------------------------------------
  // one-state memory strobes
  // ----------------------------------------
  always_comb
  begin
    req_d   = 1'b1;
    we_d    = 1'b0;
    addr_d  = 24'h0;
    wdata_d = 16'h0;
    case (st_d)
      DMIC_S_PREF:
        addr_d = pc_d;
      DMIC_S_STK:
      begin
        we_d   = 1'b1;
        addr_d = {8'h00, 16'(sp - {13'h0, cnt_d + 2'h1, 1'b0})};
        case (cnt_d)
          2'h0:    wdata_d = pc_q[15:0];
          2'h1:    wdata_d = {ccr_q, pc_q[23:16]};
          default: wdata_d = {8'h00, exr_q};
        endcase
      end
      DMIC_S_VEC:
        addr_d = vaddr(vec_q, cnt_d);
      DMIC_S_HFET:
        addr_d = {hi_q[7:0], lo_q};
      default:
        req_d = 1'b0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_q       <= DMIC_S_IDLE;
      cnt_q      <= 2'h0;
      vec_q      <= 8'h00;
      lvl_q      <= 3'h0;
      nmi_q      <= 1'b0;
      m2_q       <= 1'b0;
      pc_q       <= 24'h0;
      hi_q       <= 16'h0;
      lo_q       <= 16'h0;
      ccr_q      <= `DMIC_CCR_RST;
      exr_q      <= `DMIC_EXR_RST;
      handler_go <= 1'b0;
      mem_req    <= 1'b0;
      mem_we     <= 1'b0;
      mem_addr   <= 24'h0;
      mem_wdata  <= 16'h0;
    end
    else if (ce)
    begin
      st_q       <= st_d;
      cnt_q      <= cnt_d;
      vec_q      <= vec_d;
      lvl_q      <= lvl_d;
      nmi_q      <= nmi_d;
      m2_q       <= m2_d;
      pc_q       <= pc_d;
      hi_q       <= hi_d;
      lo_q       <= lo_d;
      ccr_q      <= ccr_d;
      exr_q      <= exr_d;
      handler_go <= go_d;
      mem_req    <= req_d;
      mem_we     <= we_d;
      mem_addr   <= addr_d;
      mem_wdata  <= wdata_d;
    end
  end
  assign handler_pc = {hi_q[7:0], lo_q};
endmodule
`default_nettype wire

// ---- testbench/dmic_chk_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// acceptance checks on the core interface
// ----------------------------------------
module dmic_chk_sva #(
  parameter int N_SRC = 8
) (
  input wire logic                clk,
  input wire logic                srst,
  input wire logic                irq_valid,
  input wire dmic_pkg::dmic_vec_t irq_vec,
  input wire dmic_pkg::dmic_lvl_t irq_level,
  input wire logic                irq_nmi,
  input wire logic                irq_ack,
  input wire logic [1:0]          mode,
  input wire logic                ccr_i,
  input wire dmic_pkg::dmic_lvl_t exr_mask
);
  import dmic_pkg::*;
  dmic_lvl_t lvl_q;
  dmic_lvl_t lvl_d;

  // level that the mask must take after an entry
  always_comb
  begin
    lvl_d = lvl_q;
    if (irq_ack)
      lvl_d = irq_nmi ? 3'h7 : irq_level;
  end

  always_ff @(posedge clk)
  begin
    lvl_q <= srst ? 3'h0 : lvl_d;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  a_ack_valid: assert property (irq_ack |-> irq_valid)
    else $error("ack without valid request");
  a_ack_gap: assert property (irq_ack |=> !irq_ack [*8])
    else $error("second ack during entry");
  a_mode0_gate: assert property (irq_valid && ccr_i && mode != 2'h2 |-> irq_nmi)
    else $error("maskable request passed global mask");
  a_mode0_level: assert property (irq_valid && !irq_nmi && mode != 2'h2 |-> irq_level == 3'h0)
    else $error("level used in mode 0");
  a_mode2_above: assert property (irq_valid && !irq_nmi && mode == 2'h2 |-> irq_level > exr_mask)
    else $error("request not above mask level");
  a_nmi_code: assert property (irq_valid && irq_nmi |-> irq_vec == 8'h07 && irq_level == 3'h7)
    else $error("bad nonmaskable vector");
  a_vec_range: assert property (irq_valid && !irq_nmi |-> irq_vec >= 8'h10 && irq_vec < 8'h10 + N_SRC)
    else $error("vector out of range");
  a_mask_set: assert property (irq_ack && mode != 2'h2 |-> ##[1:60] ccr_i)
    else $error("global mask not set");
  a_mask_load: assert property (irq_ack && mode == 2'h2 |=> ##[0:60] exr_mask == lvl_q)
    else $error("mask level not loaded");

  c_ack_m0: cover property (irq_ack && mode != 2'h2);
  c_ack_m2: cover property (irq_ack && mode == 2'h2 && !irq_nmi);
  c_ack_nmi: cover property (irq_ack && irq_nmi);
endmodule
`default_nettype wire

// ---- testbench/test_dual_mode_interrupt_controller.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dmic_regs.svh"
module test_dual_mode_interrupt_controller;
  import dmic_pkg::*;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        ce = 1'b1;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        nmi_pin = 1'b0;
  logic [1:0]  ext_pin = 2'h0;
  logic [5:0]  int_flag = 6'h00;
  logic        instr_done = 1'b0;
  logic [23:0] pc_next = 24'h123456;
  logic [15:0] sp = 16'h0800;
  logic        ccr_we = 1'b0;
  logic        exr_we = 1'b0;
  logic [7:0]  sw_data = 8'h00;
  logic [15:0] mem_rdata;
  logic        mem_req;
  logic        mem_we;
  logic [23:0] mem_addr;
  logic [15:0] mem_wdata;
  logic [7:0]  condition_code_reg;
  logic [7:0]  extended_status_reg;
  logic        handler_go;
  logic [23:0] handler_pc;
  logic        busy;
  logic [31:0] rd;
  int          errors = 0;
  int          check_count = 0;

  always #2.5 clk = ~clk;
  // vector table: both words of an entry hold its vector number
  assign mem_rdata = {8'h00, mem_addr[9:2]};

  dmic_if u_dmic_if ();
  dmic_ctrl #(.N_SRC(8), .N_EXT(2), .SRC_PER_MOD(2)) u_dmic_ctrl (.clk(clk), .srst(srst),
    .ce(ce), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .nmi_pin(nmi_pin), .ext_pin(ext_pin),
    .int_flag(int_flag), .irq(u_dmic_if));
  dmic_cpu u_dmic_cpu (.clk(clk), .srst(srst), .ce(ce), .irq(u_dmic_if),
    .instr_done(instr_done), .pc_next(pc_next), .sp(sp), .ccr_we(ccr_we),
    .ccr_wdata(sw_data), .exr_we(exr_we), .exr_wdata(sw_data), .mem_rdata(mem_rdata),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .condition_code_reg(condition_code_reg), .extended_status_reg(extended_status_reg), .handler_go(handler_go), .handler_pc(handler_pc), .busy(busy));
  dmic_chk_sva #(.N_SRC(8)) u_dmic_chk_sva (.clk(clk), .srst(srst),
    .irq_valid(u_dmic_if.irq_valid), .irq_vec(u_dmic_if.irq_vec),
    .irq_level(u_dmic_if.irq_level), .irq_nmi(u_dmic_if.irq_nmi),
    .irq_ack(u_dmic_if.irq_ack), .mode(u_dmic_if.mode), .ccr_i(u_dmic_if.ccr_i),
    .exr_mask(u_dmic_if.exr_mask));

  // ----------------------------------------
  // report and compare
  // ----------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic to_out();
    chk(32'h0, 32'h1);
    test_done();
  endtask

  // ----------------------------------------
  // register bus, software loads, entry
  // ----------------------------------------
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= wd;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50)
      to_out();
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic load(input logic is_exr, input logic [7:0] v);
    repeat (8) @(posedge clk);
    ccr_we <= ~is_exr;
    exr_we <= is_exr;
    sw_data <= v;
    @(posedge clk);
    ccr_we <= 1'b0;
    exr_we <= 1'b0;
  endtask

  task automatic entry(input logic [7:0] vec, input int nstk);
    int n;
    int nw;
    int nr;
    logic [15:0] first;
    logic [23:0] top;
    n = 0;
    nw = 0;
    nr = 0;
    first = 16'h0;
    top = 24'h0;
    while (u_dmic_if.irq_ack !== 1'b1 && n < 60)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 60)
      to_out();
    chk(u_dmic_if.irq_vec, vec);
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk(mem_req, 1'b0);
    chk(busy, 1'b1);
    @(posedge clk);
    instr_done <= 1'b1;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
      if (mem_req === 1'b1 && mem_we === 1'b1)
      begin
        if (nw == 0)
        begin
          first = mem_wdata;
          top = mem_addr;
        end
        nw++;
      end
      if (mem_req === 1'b1 && mem_we === 1'b0)
        nr++;
    end
    while (handler_go !== 1'b1 && n < 60);
    if (n >= 60)
      to_out();
    @(posedge clk);
    instr_done <= 1'b0;
    chk(n, nstk + 8);
    chk(nr, 4);
    chk(top, {8'h00, sp - 16'h0002});
    chk(nw, nstk);
    chk(first, pc_next[15:0]);
    chk(handler_pc, {vec, 8'h00, vec});
  endtask

  initial
  begin
    repeat (100000) @(posedge clk);
    to_out();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    chk(condition_code_reg, 8'h80);
    chk(extended_status_reg, 8'h07);
    bus(1'b1, `DMIC_OFF_SYSCTL, 32'h2);
    bus(1'b0, `DMIC_OFF_SYSCTL, 32'h0);
    chk(rd, 32'h2);
    bus(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, `DMIC_OFF_SYSCTL, 32'h0);
    bus(1'b1, `DMIC_OFF_ENABLE, 32'hEF);
    int_flag <= 6'h14;
    load(1'b1, 8'h07);
    @(negedge clk);
    chk(u_dmic_if.irq_valid, 1'b0);
    bus(1'b0, `DMIC_OFF_PEND, 32'h0);
    chk(rd, 32'h40);
    load(1'b0, 8'h00);
    entry(8'h16, 2);
    @(negedge clk);
    chk(condition_code_reg[7], 1'b1);
    $display("test mode0 mask done");
    @(posedge clk);
    ext_pin <= 2'h2;
    int_flag <= 6'h12;
    load(1'b0, 8'h00);
    entry(8'h11, 2);
    ext_pin <= 2'h0;
    load(1'b0, 8'h00);
    entry(8'h13, 2);
    int_flag <= 6'h10;
    load(1'b0, 8'h00);
    entry(8'h16, 2);
    $display("test mode0 order done");
    bus(1'b1, `DMIC_OFF_SYSCTL, 32'h2);
    bus(1'b1, `DMIC_OFF_LEVEL, 32'hA18);
    int_flag <= 6'h12;
    load(1'b1, 8'h05);
    repeat (8) @(negedge clk);
    chk(u_dmic_if.irq_valid, 1'b0);
    load(1'b1, 8'h84);
    entry(8'h16, 3);
    int_flag <= 6'h02;
    @(negedge clk);
    chk(extended_status_reg, 8'h05);
    load(1'b1, 8'h02);
    entry(8'h13, 3);
    int_flag <= 6'h00;
    @(negedge clk);
    chk(extended_status_reg, 8'h03);
    $display("test mode2 levels done");
    @(posedge clk);
    nmi_pin <= 1'b1;
    entry(8'h07, 3);
    nmi_pin <= 1'b0;
    @(negedge clk);
    chk(extended_status_reg[2:0], 3'h7);
    bus(1'b0, `DMIC_OFF_LASTV, 32'h0);
    chk(rd, 32'h07);
    bus(1'b1, `DMIC_OFF_SYSCTL, 32'h0);
    nmi_pin <= 1'b1;
    entry(8'h07, 2);
    nmi_pin <= 1'b0;
    $display("test nonmaskable done");
    load(1'b0, 8'h00);
    int_flag <= 6'h01;
    @(negedge clk);
    chk(u_dmic_if.irq_valid, 1'b0);
    @(negedge clk);
    chk(u_dmic_if.irq_valid, 1'b0);
    @(negedge clk);
    chk(u_dmic_if.irq_valid, 1'b1);
    entry(8'h12, 2);
    int_flag <= 6'h00;
    $display("test timing done");
    test_done();
  end
endmodule
`default_nettype wire
